// ### core/amp_diag_pkg.sv
package amp_diag_pkg;
   localparam int ADDR_W = 7;
   localparam int NUM_CH = 4;
   localparam int DIAG_W = 32;
   localparam logic [2:0] LAST_BIT = 3'h7;
   localparam logic [1:0] WR_BYTES = 2'h2;
   localparam logic [2:0] SYNC_IDLE = 3'h7;
   localparam logic [DIAG_W-1:0] DIAG_RESET = 32'h0000_0000;

   // First instruction byte, D7 down to D0
   typedef struct packed {
      logic zero;
      logic diag_en;
      logic offset_en;
      logic gain_front_low;
      logic gain_rear_low;
      logic unmute_front;
      logic unmute_rear;
      logic clip_threshold_select;
   } ctrl_one_t;

   // Second instruction byte, D7 down to D0
   typedef struct packed {
      logic [2:0] zero_hi;
      logic operate;
      logic line_driver_mode;
      logic current_det_en;
      logic [1:0] zero_lo;
   } ctrl_two_t;

   localparam ctrl_one_t CTRL_ONE_RESET = 8'h00;
   localparam ctrl_two_t CTRL_TWO_RESET = 8'h00;

   // Channel fault flags, D5 down to D0 of a diagnostic byte
   typedef struct packed {
      logic current_low;
      logic permanent;
      logic short_load;
      logic open_or_offset;
      logic short_supply;
      logic short_ground;
   } chan_fault_t;

   typedef struct packed {
      logic thermal_warning;
      logic cycle_done;
      logic offset_active;
      logic current_active;
   } diag_status_t;

   typedef enum logic [2:0] {
      ST_IDLE,
      ST_RX,
      ST_RX_ACK,
      ST_TX,
      ST_TX_ACK
   } link_state_t;

   typedef struct packed {
      logic [2:0] scl_sync;
      logic [2:0] sda_sync;
      logic scl_f;
      logic sda_f;
      logic scl_prev;
      logic sda_prev;
      link_state_t state;
      logic is_addr;
      logic is_read;
      logic got_byte;
      logic [2:0] bcnt;
      logic [1:0] bidx;
      logic [7:0] shreg;
      logic sda_oe_n;
      ctrl_one_t ctrl1;
      ctrl_two_t ctrl2;
      logic [DIAG_W-1:0] latched;
      logic [DIAG_W-1:0] sending;
      logic restart;
      logic window;
   } slave_state_t;
endpackage

// ### core/amp_diag_slave.sv
`timescale 1ns/1ps
// Behaviour
// [RULE1] Host leaves standby with diagnostics on, waits 500 ms, then unmutes.
// [RULE2] Host mutes, waits 20 ms, then disables diagnostics and standby.
// [RULE3] Host enables diagnostics, waits 200 ms, reads until faults vanish.
// [RULE4] Host plays tone, enables current test, waits 3 cycles, rereads.
// [RULE5] Host sets offset enable, waits 30ms, rereads until offset clears.
// [RULE6] Data line changes only while clock is low.
// [RULE7] Data fall with clock high starts, data rise with clock high stops.
// [RULE8] Bytes are eight bits, MSB first, then one acknowledge bit.
// [RULE9] Receiver pulls data low during acknowledge; transmitter releases it.
// [RULE10] Address bit 0 gives direction: 0 write, 1 read.
// [RULE11] A write carries two control bytes, first then second.
// [RULE12] A read returns four diagnostic bytes: LF, LR, RF, RR.
// [RULE13] Control one: D7 zero, D6 diagnostics, D5 offset detection.
// [RULE14] Control one: D4/D3 gain 26dB or 12dB, D2/D1 unmute pairs.
// [RULE15] Control one: D0 clip threshold, 0 is 2 percent, 1 is 10.
// [RULE16] Control two: D7,D6,D5,D1,D0 zero; D4 operate versus standby.
// [RULE17] Control two: D3 selects line-driver diagnostic thresholds.
// [RULE18] Control two: D2 enables output-current detection.
// [RULE19] First diagnostic byte: D7 thermal warning, D6 cycle terminated.
// [RULE20] Channel byte: D5 low current, D4 permanent, D3 shorted load.
// [RULE21] Channel byte: D2 open or offset, D1 short supply, D0 ground.
// [RULE22] Second byte D7 offset active, D6 sensor active; fourth undefined.
// [RULE23] Third byte echoes standby setting in D7, diagnostics in D6.
// [RULE24] A read restarts diagnostics and returns the previous results.
// [RULE25] Offset window runs from last read or enable to this read.
// [RULE26] Only a matching seven-bit slave address is answered.
module amp_diag_slave
   import amp_diag_pkg::*;
#(
   parameter logic [ADDR_W-1:0] SLAVE_ADDR = 7'h6c
) (
   input wire logic mclk, // System clock
   input wire logic sys_rst, // Synchronous reset
   input wire logic scl_in, // Bus clock pin
   input wire logic sda_in, // Bus data pin level
   output logic sda_out, // Data pin drive value
   output logic sda_oe_n, // Data pin drive enable
   input chan_fault_t [NUM_CH-1:0] chan_fault, // Live channel faults
   input diag_status_t diag_status, // Live global status
   output ctrl_one_t ctrl_one, // First control byte
   output ctrl_two_t ctrl_two, // Second control byte
   output logic diag_restart, // Restart all diag cycles
   output logic offset_window_start // Offset window opens
);

   slave_state_t st;
   slave_state_t nx;
   logic scl_rise;
   logic scl_fall;
   logic start_c;
   logic stop_c;

   // [RULE13] reserved bit forced
   function automatic ctrl_one_t clean_one(input logic [7:0] b);
      ctrl_one_t c;
      c = b;
      c.zero = 1'b0;
      return c;
   endfunction

   // [RULE16] reserved bits forced
   function automatic ctrl_two_t clean_two(input logic [7:0] b);
      ctrl_two_t c;
      c = b;
      c.zero_hi = 3'h0;
      c.zero_lo = 2'h0;
      return c;
   endfunction

   // [RULE19] [RULE20] [RULE21] [RULE22] [RULE23] diag byte layout
   function automatic logic [DIAG_W-1:0] build_diag(
      input chan_fault_t [NUM_CH-1:0] f,
      input diag_status_t s,
      input ctrl_one_t c1,
      input ctrl_two_t c2);
      return {s.thermal_warning, s.cycle_done, f[0],
              s.offset_active, s.current_active, f[1],
              c2.operate, c1.diag_en, f[2],
              2'b00, f[3]};
   endfunction

   // [RULE12] byte zero is left front
   function automatic logic [7:0] pick_byte(
      input logic [DIAG_W-1:0] w,
      input logic [1:0] i);
      return w[(DIAG_W-8)-8*i +: 8];
   endfunction

   assign scl_rise = st.scl_f & ~st.scl_prev;
   assign scl_fall = ~st.scl_f & st.scl_prev;
   // [RULE7] start and stop seen with clock high
   assign start_c = st.scl_f & st.scl_prev & st.sda_prev & ~st.sda_f;
   assign stop_c = st.scl_f & st.scl_prev & ~st.sda_prev & st.sda_f;

   always_comb begin
      logic [7:0] b;
      b = 8'h00;
      nx = st;
      nx.restart = 1'b0;
      nx.window = 1'b0;
      // Third stage must agree with second before a level counts
      nx.scl_sync = {st.scl_sync[1:0], scl_in};
      nx.sda_sync = {st.sda_sync[1:0], sda_in};
      if (st.scl_sync[1] == st.scl_sync[2]) begin
         nx.scl_f = st.scl_sync[2];
      end
      if (st.sda_sync[1] == st.sda_sync[2]) begin
         nx.sda_f = st.sda_sync[2];
      end
      nx.scl_prev = st.scl_f;
      nx.sda_prev = st.sda_f;
      if (start_c) begin
         // [RULE7] start resyncs even mid-byte
         nx.state = ST_RX;
         nx.is_addr = 1'b1;
         nx.bcnt = 3'h0;
         nx.got_byte = 1'b0;
         nx.sda_oe_n = 1'b1;
      end else if (stop_c) begin
         // [RULE7] stop frees the line
         nx.state = ST_IDLE;
         nx.sda_oe_n = 1'b1;
      end else begin
         case (st.state)
            ST_IDLE: begin
               nx.sda_oe_n = 1'b1;
            end
            ST_RX: begin
               if (scl_rise) begin
                  // [RULE8] shift in MSB first
                  nx.shreg = {st.shreg[6:0], st.sda_f};
                  nx.bcnt = 3'(st.bcnt + 3'h1);
                  nx.got_byte = (st.bcnt == LAST_BIT);
               end else if (scl_fall && st.got_byte) begin
                  nx.got_byte = 1'b0;
                  if (st.is_addr) begin
                     // [RULE26] foreign address left alone
                     if (st.shreg[7:1] == SLAVE_ADDR) begin
                        // [RULE9] acknowledge own address
                        nx.sda_oe_n = 1'b0;
                        nx.state = ST_RX_ACK;
                        nx.is_addr = 1'b0;
                        nx.bidx = 2'h0;
                        // [RULE10] direction bit
                        nx.is_read = st.shreg[0];
                        if (st.shreg[0]) begin
                           // [RULE24] send old results, restart
                           nx.sending = st.latched;
                           nx.latched = build_diag(chan_fault,
                              diag_status, st.ctrl1, st.ctrl2);
                           nx.restart = 1'b1;
                           // [RULE25] read closes and reopens window
                           nx.window = 1'b1;
                        end
                     end else begin
                        nx.state = ST_IDLE;
                     end
                  end else if (st.bidx < WR_BYTES) begin
                     // [RULE11] two bytes, first then second
                     nx.sda_oe_n = 1'b0;
                     nx.state = ST_RX_ACK;
                     nx.bidx = 2'(st.bidx + 2'h1);
                     if (st.bidx == 2'h0) begin
                        nx.ctrl1 = clean_one(st.shreg);
                        // [RULE25] enable rising opens window
                        nx.window = st.shreg[5] & ~st.ctrl1.offset_en;
                     end else begin
                        nx.ctrl2 = clean_two(st.shreg);
                     end
                  end else begin
                     // Surplus write bytes are not acknowledged
                     nx.state = ST_IDLE;
                  end
               end
            end
            ST_RX_ACK: begin
               if (scl_fall) begin
                  nx.bcnt = 3'h0;
                  nx.sda_oe_n = 1'b1;
                  if (st.is_read) begin
                     b = pick_byte(st.sending, st.bidx);
                     nx.shreg = b;
                     // [RULE6] new bit only after clock fall
                     nx.sda_oe_n = b[7];
                     nx.state = ST_TX;
                  end else begin
                     nx.state = ST_RX;
                  end
               end
            end
            ST_TX: begin
               if (scl_fall) begin
                  if (st.bcnt == LAST_BIT) begin
                     // [RULE9] release for master acknowledge
                     nx.sda_oe_n = 1'b1;
                     nx.state = ST_TX_ACK;
                     nx.bidx = 2'(st.bidx + 2'h1);
                  end else begin
                     // [RULE8] next lower bit
                     nx.shreg = {st.shreg[6:0], 1'b0};
                     nx.sda_oe_n = st.shreg[6];
                     nx.bcnt = 3'(st.bcnt + 3'h1);
                  end
               end
            end
            ST_TX_ACK: begin
               if (scl_rise && st.sda_f) begin
                  // Master refused, stay off the line
                  nx.state = ST_IDLE;
               end else if (scl_fall) begin
                  // [RULE12] next channel byte; wraps after four
                  b = pick_byte(st.sending, st.bidx);
                  nx.shreg = b;
                  nx.sda_oe_n = b[7];
                  nx.bcnt = 3'h0;
                  nx.state = ST_TX;
               end
            end
            default: begin
               nx.state = ST_IDLE;
               nx.sda_oe_n = 1'b1;
            end
         endcase
      end
   end

   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         st <= '0;
         st.scl_sync <= SYNC_IDLE;
         st.sda_sync <= SYNC_IDLE;
         st.scl_f <= 1'b1;
         st.sda_f <= 1'b1;
         st.scl_prev <= 1'b1;
         st.sda_prev <= 1'b1;
         st.state <= ST_IDLE;
         st.sda_oe_n <= 1'b1;
         st.ctrl1 <= CTRL_ONE_RESET;
         st.ctrl2 <= CTRL_TWO_RESET;
         st.latched <= DIAG_RESET;
         st.sending <= DIAG_RESET;
      end else begin
         st <= nx;
      end
   end

   // Open drain: only ever pulls low
   assign sda_out = 1'b0;
   assign sda_oe_n = st.sda_oe_n;
   // [RULE14] [RULE15] [RULE17] [RULE18] settings to the amplifier
   assign ctrl_one = st.ctrl1;
   assign ctrl_two = st.ctrl2;
   assign diag_restart = st.restart;
   assign offset_window_start = st.window;

   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (sys_rst);

   a_sda_hold_high: assert property ( // RULE6
      $fell(st.sda_oe_n) |-> !$past(st.scl_f))
      else $error("data driven low while clock high");
   a_start_seen: assert property ( // RULE7
      start_c |=> st.state == ST_RX && st.is_addr && st.bcnt == 3'h0)
      else $error("start not taken");
   a_stop_seen: assert property ( // RULE7
      stop_c |=> st.state == ST_IDLE && st.sda_oe_n)
      else $error("stop not taken");
   a_tx_ack_release: assert property ( // RULE8
      (st.state == ST_TX && scl_fall && st.bcnt == LAST_BIT && !start_c
       && !stop_c) |=> st.sda_oe_n && st.state == ST_TX_ACK)
      else $error("line not released after eighth bit");
   a_wr_ack_drive: assert property ( // RULE9
      (st.state == ST_RX && scl_fall && st.got_byte && !st.is_addr
       && st.bidx < WR_BYTES && !start_c && !stop_c)
      |=> !st.sda_oe_n ##1 !st.sda_oe_n)
      else $error("write byte not acknowledged");
   a_dir_bit: assert property ( // RULE10
      (st.state == ST_RX && scl_fall && st.got_byte && st.is_addr
       && st.shreg[7:1] == SLAVE_ADDR && !start_c && !stop_c)
      |=> st.is_read == $past(st.shreg[0]) && !st.sda_oe_n)
      else $error("direction bit misread");
   a_addr_ignore: assert property ( // RULE26
      (st.state == ST_RX && scl_fall && st.got_byte && st.is_addr
       && st.shreg[7:1] != SLAVE_ADDR && !start_c && !stop_c)
      |=> st.state == ST_IDLE && st.sda_oe_n)
      else $error("foreign address answered");
   a_ctrl_one_zero: assert property ( // RULE13
      ctrl_one.zero == 1'b0)
      else $error("control one D7 set");
   a_ctrl_two_zero: assert property ( // RULE16
      ctrl_two.zero_hi == 3'h0 && ctrl_two.zero_lo == 2'h0)
      else $error("control two reserved bit set");
   a_first_byte: assert property ( // RULE12
      (st.state == ST_TX && $past(st.state) == ST_RX_ACK)
      |-> st.shreg == st.sending[31:24])
      else $error("read did not start with left front");
   a_read_restart: assert property ( // RULE24
      diag_restart |-> st.sending == $past(st.latched)
      && offset_window_start)
      else $error("read returned fresh results");
   a_echo_setting: assert property ( // RULE23
      diag_restart |-> st.latched[15] == ctrl_two.operate
      && st.latched[14] == ctrl_one.diag_en)
      else $error("third byte echo wrong");
   a_window_open: assert property ( // RULE25
      $rose(ctrl_one.offset_en) |-> offset_window_start)
      else $error("offset enable did not open window");
   a_nack_release: assert property ( // RULE9
      (st.state == ST_TX_ACK && scl_rise && st.sda_f && !start_c
       && !stop_c) |=> st.state == ST_IDLE && st.sda_oe_n)
      else $error("device kept line after master refusal");
   a_surplus_nack: assert property ( // RULE11
      (st.state == ST_RX && scl_fall && st.got_byte && !st.is_addr
       && st.bidx == WR_BYTES && !start_c && !stop_c)
      |=> st.state == ST_IDLE && st.sda_oe_n)
      else $error("third write byte acknowledged");
   a_rx_shift: assert property ( // RULE8
      (st.state == ST_RX && scl_rise && !start_c && !stop_c)
      |=> st.shreg == {$past(st.shreg[6:0]), $past(st.sda_f)})
      else $error("received bit not shifted in");
   a_tx_shift: assert property ( // RULE8
      (st.state == ST_TX && scl_fall && st.bcnt != LAST_BIT && !start_c
       && !stop_c) |=> st.bcnt == 3'($past(st.bcnt) + 3'h1))
      else $error("transmit bit count skipped");
   a_restart_pulse: assert property ( // RULE24
      diag_restart |=> !diag_restart)
      else $error("restart pulse longer than one cycle");

   c_offset_enable: cover property (
      $rose(ctrl_one.offset_en));

   c_write_two: cover property (
      st.state == ST_RX_ACK && st.bidx == WR_BYTES && !st.is_read);
   c_read_four: cover property (
      st.state == ST_TX_ACK && st.bidx == 2'h0 && st.is_read);
   c_addr_miss: cover property (
      st.state == ST_RX && scl_fall && st.got_byte && st.is_addr
      && st.shreg[7:1] != SLAVE_ADDR);
   c_master_nack: cover property (
      st.state == ST_TX_ACK && scl_rise && st.sda_f);

endmodule // amp_diag_slave

// ### testbench/i2c_master_model.sv
`timescale 1ns/1ps
module i2c_master_model (
   input wire logic mclk, // System clock
   input wire logic sda, // Resolved data wire
   output logic scl, // Bus clock drive
   output logic sda_rel // High releases data wire
);
   initial begin
      scl = 1'b1;
      sda_rel = 1'b1;
   end
   task automatic wait_clk(input int n);
      repeat (n) @(negedge mclk);
   endtask
   task automatic start();
      sda_rel = 1'b1;
      wait_clk(5);
      scl = 1'b1;
      wait_clk(4);
      sda_rel = 1'b0;
      wait_clk(4);
      scl = 1'b0;
   endtask
   task automatic stop();
      sda_rel = 1'b0;
      wait_clk(5);
      scl = 1'b1;
      wait_clk(4);
      sda_rel = 1'b1;
      wait_clk(4);
   endtask
   // data set while clock low
   // Long low, short high: device answers about 5 cycles after a fall
   task automatic bit_io(input logic b, output logic seen);
      sda_rel = b;
      wait_clk(5);
      scl = 1'b1;
      wait_clk(3);
      seen = sda;
      scl = 1'b0;
   endtask
   task automatic send_byte(input logic [7:0] b, output logic ack_n);
      logic s;
      for (int i = 7; i >= 0; i--) begin
         bit_io(b[i], s);
      end
      bit_io(1'b1, ack_n);
   endtask
   // master acks all but the last byte
   task automatic recv_byte(input logic last, output logic [7:0] b);
      logic s;
      for (int i = 7; i >= 0; i--) begin
         bit_io(1'b1, s);
         b[i] = s;
      end
      bit_io(last, s);
   endtask
endmodule // i2c_master_model

// ### testbench/test_amp_diag_slave.sv
`timescale 1ns/1ps
module test_amp_diag_slave
   import amp_diag_pkg::*;
;
   localparam logic [ADDR_W-1:0] ADDR = 7'h2a;
   logic mclk, sys_rst, scl, m_rel, sda_out, sda_oe_n, diag_restart, ows;
   chan_fault_t [NUM_CH-1:0] chan_fault;
   diag_status_t diag_status;
   ctrl_one_t ctrl_one;
   ctrl_two_t ctrl_two;
   int bad_count = 0, tests_run = 0, n_rst = 0, n_off = 0;
   // Open drain with pull-up: low if either party pulls
   wire logic sda = m_rel & (sda_oe_n | sda_out);

   amp_diag_slave #(.SLAVE_ADDR(ADDR)) i_dut (
      .mclk(mclk), .sys_rst(sys_rst), .scl_in(scl), .sda_in(sda),
      .sda_out(sda_out), .sda_oe_n(sda_oe_n), .chan_fault(chan_fault),
      .diag_status(diag_status), .ctrl_one(ctrl_one), .ctrl_two(ctrl_two),
      .diag_restart(diag_restart), .offset_window_start(ows));
   i2c_master_model i_master (
      .mclk(mclk), .sda(sda), .scl(scl), .sda_rel(m_rel));

   initial begin
      mclk = 1'b0;
      forever #5 mclk = ~mclk;
   end
   always @(posedge mclk) begin
      if (diag_restart === 1'b1) n_rst++;
      if (ows === 1'b1) n_off++;
   end

   task automatic check(input string what, input logic [7:0] seen, exp);
      tests_run++;
      if (seen !== exp) begin
         bad_count++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic report_and_stop();
      $display("mismatches %0d of %0d checks", bad_count, tests_run);
      if (bad_count == 0 && tests_run > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask
   // Write n bytes; only the first two may be acked
   task automatic wr(input logic [6:0] a, input logic [7:0] b1, b2, b3,
                     input int n);
      logic ack_n;
      logic [7:0] b [3];
      b = '{b1, b2, b3};
      i_master.start();
      i_master.send_byte({a, 1'b0}, ack_n);
      check("addr ack", ack_n, a !== ADDR);
      if (ack_n === 1'b0) begin
         for (int k = 0; k < n; k++) begin
            i_master.send_byte(b[k], ack_n);
            check("data ack", ack_n, k >= 2);
         end
      end
      i_master.stop();
   endtask
   task automatic rd(input logic [7:0] e [4]);
      logic ack_n;
      logic [7:0] v;
      i_master.start();
      i_master.send_byte({ADDR, 1'b1}, ack_n);
      check("read addr ack", ack_n, 1'b0);
      for (int k = 0; k < 4; k++) begin
         i_master.recv_byte(k == 3, v);
         check("diag byte", v, e[k]);
      end
      i_master.stop();
   endtask

   initial begin
      sys_rst = 1'b1;
      chan_fault = {6'h3f, 6'h0c, 6'h12, 6'h21};
      diag_status = 4'hb;
      repeat (6) @(negedge mclk);
      sys_rst = 1'b0;
      repeat (4) @(negedge mclk);
      check("ctrl one rst", ctrl_one, 8'h00);
      check("ctrl two rst", ctrl_two, 8'h00);
      check("oe rst", sda_oe_n, 1'b1);
      check("drive value", sda_out, 1'b0);
      wr(ADDR ^ 7'h01, 8'h7f, 8'h1c, 8'h00, 2);
      check("ctrl one", ctrl_one, 8'h00);
      // Reserved bits must not stick
      wr(ADDR, 8'hff, 8'hff, 8'h00, 2);
      check("ctrl one", ctrl_one, 8'h7f);
      check("ctrl two", ctrl_two, 8'h1c);
      check("offset start", n_off, 1);
      wr(ADDR, 8'h55, 8'h08, 8'h33, 3);
      check("ctrl one", ctrl_one, 8'h55);
      check("ctrl two", ctrl_two, 8'h08);
      rd('{8'h00, 8'h00, 8'h00, 8'h00});
      check("restarts", n_rst, 1);
      rd('{8'ha1, 8'hd2, 8'h4c, 8'h3f});
      chan_fault = '0;
      diag_status = '0;
      wr(ADDR, 8'h40, 8'h10, 8'h00, 2);
      // Old results once more, then the new state
      rd('{8'ha1, 8'hd2, 8'h4c, 8'h3f});
      rd('{8'h00, 8'h00, 8'hc0, 8'h00});
      check("restarts", n_rst, 4);
      check("offset start", n_off, 5);
      // Host turn-on: operate with diagnostics, pause, then unmute
      repeat (50) @(negedge mclk);
      wr(ADDR, 8'h46, 8'h10, 8'h00, 2);
      check("unmuted", ctrl_one, 8'h46);
      // Installation check: pause, then read
      repeat (20) @(negedge mclk);
      rd('{8'h00, 8'h00, 8'hc0, 8'h00});
      // Offset test: enable opens the window, pause, read
      wr(ADDR, 8'h66, 8'h10, 8'h00, 2);
      check("offset start", n_off, 7);
      repeat (30) @(negedge mclk);
      rd('{8'h00, 8'h00, 8'hc0, 8'h00});
      // Tone test: current detection on, pause, reread
      wr(ADDR, 8'h66, 8'h14, 8'h00, 2);
      check("current det", ctrl_two, 8'h14);
      repeat (30) @(negedge mclk);
      rd('{8'h00, 8'h00, 8'hc0, 8'h00});
      // Turn-off: mute, pause, then standby with diagnostics off
      wr(ADDR, 8'h60, 8'h14, 8'h00, 2);
      repeat (20) @(negedge mclk);
      wr(ADDR, 8'h00, 8'h00, 8'h00, 2);
      check("diag off", ctrl_one, 8'h00);
      check("standby", ctrl_two, 8'h00);
      check("offset start", n_off, 9);
      report_and_stop();
   end
   initial begin
      #200000;
      bad_count++;
      report_and_stop();
   end
endmodule // test_amp_diag_slave
